// ---- rtl/eac_top.sv ----
// Notes on behaviour
// - byte mode data then address starts programming
// - completion sets done flag in control bit 7
// - interrupt needs both enables and done flag
// - any reset clears the armed write state
// - unarmed address write after reset reads
// - last data written is the one programmed
// - data write arms only in byte mode
// - control keeps mode and address bit 8
// - row fill writes whole row, low six ignored
// - data register keeps pattern after fill
// - block mode address write fills whole array
// - each program or fill takes about 4 ms
// - voltage fault sets error flag in bit 6
// - mode bits 5:4: byte, reserved, row, block
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
module eac_top #(
  parameter int PROG_CYCLES = eac_pkg::PROG_CYCLES_DFLT
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HV_FAULT,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic IRQ
);

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic hv_meta_q;
  logic hv_sync_q;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      hv_meta_q <= 1'b0;
      hv_sync_q <= 1'b0;
    end else begin
      hv_meta_q <= HV_FAULT;
      hv_sync_q <= hv_meta_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  eac_op_if op_if ();
  logic take;
  logic wr_q;
  eac_pkg::eac_reg_t wreg_q;
  eac_pkg::eac_reg_t rreg;
  logic [7:0] rd_byte;
  logic [31:0] hrdata_q;
  logic ready_q;
  logic [7:0] wbyte;
  logic wr_ctrl;
  logic wr_data;
  logic wr_laddr;
  logic wr_irq_enable_reg1;
  logic wr_irq_enable_reg0;
  logic eng_busy;
  logic go;
  eac_pkg::eac_mode_t mode_q;
  logic addr8_q;
  logic done_flag_q;
  logic ee_voltage_error_flag_q;
  logic [7:0] data_q;
  logic [7:0] laddr_q;
  logic armed_q;
  logic ee_ie_q;
  logic gie_q;
  logic irq_q;
  logic start_q;
  eac_pkg::eac_mode_t op_q;
  logic op_rd_q;
  logic [8:0] op_addr_q;
  logic [7:0] op_wdata_q;

  function automatic eac_pkg::eac_reg_t reg_decode(input logic [31:0] a);
    if (a == eac_pkg::OFF_CONTROL) begin
      reg_decode = eac_pkg::REG_CONTROL;
    end else if (a == eac_pkg::OFF_DATA) begin
      reg_decode = eac_pkg::REG_DATA;
    end else if (a == eac_pkg::OFF_LOW_ADDRESS) begin
      reg_decode = eac_pkg::REG_LOW_ADDRESS;
    end else if (a == eac_pkg::OFF_IRQ_ENABLE1) begin
      reg_decode = eac_pkg::REG_IRQ_ENABLE1;
    end else if (a == eac_pkg::OFF_IRQ_ENABLE0) begin
      reg_decode = eac_pkg::REG_IRQ_ENABLE0;
    end else begin
      reg_decode = eac_pkg::REG_NONE;
    end
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  assign take = HSEL && HTRANS[1] && HREADY;
  assign rreg = reg_decode(HADDR);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rreg)
      eac_pkg::REG_CONTROL: begin
        rd_byte[eac_pkg::BIT_DONE] = done_flag_q;
        rd_byte[eac_pkg::BIT_VOLT_ERR] = ee_voltage_error_flag_q;
        rd_byte[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO] = mode_q;
        rd_byte[eac_pkg::BIT_ADDR8] = addr8_q;
      end
      eac_pkg::REG_DATA: rd_byte = data_q;
      eac_pkg::REG_LOW_ADDRESS: rd_byte = laddr_q;
      eac_pkg::REG_IRQ_ENABLE1: rd_byte[eac_pkg::BIT_IRQ_EN] = ee_ie_q;
      eac_pkg::REG_IRQ_ENABLE0: rd_byte[eac_pkg::BIT_IRQ_EN] = gie_q;
      eac_pkg::REG_NONE: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wreg_q <= eac_pkg::REG_NONE;
      hrdata_q <= 32'h0000_0000;
      ready_q <= 1'b1;
    end else begin
      wr_q <= take && HWRITE && (HSIZE == eac_pkg::SIZE_WORD);
      wreg_q <= rreg;
      ready_q <= 1'b1;
      if (take && !HWRITE) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign wbyte = HWDATA[7:0];
  assign wr_ctrl = wr_q && (wreg_q == eac_pkg::REG_CONTROL);
  assign wr_data = wr_q && (wreg_q == eac_pkg::REG_DATA);
  assign wr_laddr = wr_q && (wreg_q == eac_pkg::REG_LOW_ADDRESS);
  assign wr_irq_enable_reg1 = wr_q && (wreg_q == eac_pkg::REG_IRQ_ENABLE1);
  assign wr_irq_enable_reg0 = wr_q && (wreg_q == eac_pkg::REG_IRQ_ENABLE0);

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= eac_pkg::eac_mode_t'(
        eac_pkg::CONTROL_RST[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO]);
      addr8_q <= eac_pkg::CONTROL_RST[eac_pkg::BIT_ADDR8];
    end else if (wr_ctrl) begin
      mode_q <= eac_pkg::eac_mode_t'(
        wbyte[eac_pkg::BIT_MODE_HI:eac_pkg::BIT_MODE_LO]);
      addr8_q <= wbyte[eac_pkg::BIT_ADDR8];
    end
  end

  // completion wins over a clearing write in the same cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_q <= eac_pkg::CONTROL_RST[eac_pkg::BIT_DONE];
    end else if (op_if.done) begin
      done_flag_q <= 1'b1;
    end else if (wr_ctrl && !wbyte[eac_pkg::BIT_DONE]) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ee_voltage_error_flag_q <= eac_pkg::CONTROL_RST[eac_pkg::BIT_VOLT_ERR];
    end else if (op_if.hv_err) begin
      ee_voltage_error_flag_q <= 1'b1;
    end else if (wr_ctrl && !wbyte[eac_pkg::BIT_VOLT_ERR]) begin
      ee_voltage_error_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // data, address and enables
  // ****************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= eac_pkg::DATA_RST;
    end else if (wr_data) begin
      data_q <= wbyte;
    end else if (op_if.done_rd) begin
      data_q <= op_if.rdata;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      laddr_q <= eac_pkg::LOW_ADDRESS_RST;
    end else if (wr_laddr) begin
      laddr_q <= wbyte;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ee_ie_q <= 1'b0;
      gie_q <= 1'b0;
    end else begin
      if (wr_irq_enable_reg1) begin
        ee_ie_q <= wbyte[eac_pkg::BIT_IRQ_EN];
      end
      if (wr_irq_enable_reg0) begin
        gie_q <= wbyte[eac_pkg::BIT_IRQ_EN];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_flag_q && ee_ie_q && gie_q;
    end
  end

  // ****************************************
  // operation launch
  // ****************************************
  assign eng_busy = op_if.busy || start_q;
  assign go = wr_laddr && !eng_busy &&
              (mode_q != eac_pkg::MODE_RESERVED);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (wr_data && mode_q == eac_pkg::MODE_BYTE) begin
      armed_q <= 1'b1;
    end else if (go && mode_q == eac_pkg::MODE_BYTE) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      op_q <= eac_pkg::MODE_BYTE;
      op_rd_q <= 1'b0;
      op_addr_q <= '0;
      op_wdata_q <= '0;
    end else begin
      start_q <= go;
      if (go) begin
        op_q <= mode_q;
        op_rd_q <= (mode_q == eac_pkg::MODE_BYTE) && !armed_q;
        op_addr_q <= {addr8_q, wbyte};
        op_wdata_q <= data_q;
      end
    end
  end

  assign op_if.start = start_q;
  assign op_if.op = op_q;
  assign op_if.rd = op_rd_q;
  assign op_if.addr = op_addr_q;
  assign op_if.wdata = op_wdata_q;
  assign op_if.hv_fault = hv_sync_q;

  eac_engine #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_engine (
    .clk(CLK),
    .rst_n(rst_n),
    .op_if(op_if)
  );

  assign HRDATA = hrdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP = 1'b0;
  assign IRQ = irq_q;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);
  property p_byte_write;
    wr_laddr && !eng_busy && mode_q == eac_pkg::MODE_BYTE && armed_q |=>
      start_q && !op_rd_q && op_addr_q == {$past(addr8_q), $past(wbyte)};
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("armed address write did not start a write");
  property p_unarmed_read;
    wr_laddr && !eng_busy && mode_q == eac_pkg::MODE_BYTE && !armed_q |=>
      start_q && op_rd_q;
  endproperty
  a_unarmed_read: assert property (p_unarmed_read)
    else $error("unarmed address write did not read");
  property p_last_data;
    wr_data ##1 (!wr_data && !op_if.done_rd) [*2] ##1 wr_laddr &&
      !eng_busy && mode_q == eac_pkg::MODE_BYTE |=>
      op_wdata_q == $past(wbyte, 4);
  endproperty
  a_last_data: assert property (p_last_data)
    else $error("programmed value is not the last data written");
  property p_mode_gate;
    wr_data && mode_q != eac_pkg::MODE_BYTE && !armed_q |=> !armed_q;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("data write armed outside byte mode");
  property p_done_flag;
    op_if.done |=> done_flag_q ##1 (IRQ == (ee_ie_q && gie_q)
      || !$stable(gie_q) || !$stable(ee_ie_q) || !done_flag_q);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion did not set done flag");
  property p_irq_gate;
    !ee_ie_q || !gie_q |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without both enables");
  property p_busy_ignore;
    wr_laddr && eng_busy |=> !start_q;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("address write started a second operation");
  property p_keep_pattern;
    op_if.done && !op_if.done_rd && !wr_data |=> $stable(data_q);
  endproperty
  a_keep_pattern: assert property (p_keep_pattern)
    else $error("fill pattern lost after completion");
  property p_mode_held;
    !wr_ctrl |=> $stable(mode_q) && $stable(addr8_q);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("mode changed without a control write");
  property p_volt_err;
    op_if.hv_err |=> ee_voltage_error_flag_q;
  endproperty
  a_volt_err: assert property (p_volt_err)
    else $error("voltage fault not flagged");
  property p_fill_start;
    wr_laddr && !eng_busy && mode_q[1] |=>
      start_q && !op_rd_q && op_q == $past(mode_q) ##1 op_if.busy;
  endproperty
  a_fill_start: assert property (p_fill_start)
    else $error("fill did not start");
endmodule

// ---- include/eac_pkg.sv ----
package eac_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] OFF_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFF_DATA = 32'h0000_0004;
  localparam logic [31:0] OFF_LOW_ADDRESS = 32'h0000_0008;
  localparam logic [31:0] OFF_IRQ_ENABLE1 = 32'h0000_000C;
  localparam logic [31:0] OFF_IRQ_ENABLE0 = 32'h0000_0010;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIT_DONE = 7;
  localparam int BIT_VOLT_ERR = 6;
  localparam int BIT_MODE_HI = 5;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_ADDR8 = 0;
  localparam int BIT_IRQ_EN = 7;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] LOW_ADDRESS_RST = 8'h00;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ****************************************
  // array geometry
  // ****************************************
  localparam int ADDR_W = 9;
  localparam int ARRAY_BYTES = 512;
  localparam int ROW_LSB = 6;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_MS = 4;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int READ_CYCLES = 3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_BYTE = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_ROW = 2'h2,
    MODE_BLOCK = 2'h3
  } eac_mode_t;

  typedef enum {
    REG_NONE,
    REG_CONTROL,
    REG_DATA,
    REG_LOW_ADDRESS,
    REG_IRQ_ENABLE1,
    REG_IRQ_ENABLE0
  } eac_reg_t;

endpackage

// ---- include/eac_op_if.sv ----
interface eac_op_if;
  logic start;
  eac_pkg::eac_mode_t op;
  logic rd;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic hv_fault;
  logic busy;
  logic done;
  logic done_rd;
  logic hv_err;
  logic [7:0] rdata;

  modport ctl (
    output start, op, rd, addr, wdata, hv_fault,
    input busy, done, done_rd, hv_err, rdata
  );
  modport eng (
    input start, op, rd, addr, wdata, hv_fault,
    output busy, done, done_rd, hv_err, rdata
  );
endinterface

// ---- rtl/eac_engine.sv ----
module eac_engine #(
  parameter int PROG_CYCLES = eac_pkg::PROG_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic rst_n,
  eac_op_if.eng op_if
);

  // ****************************************
  // sequencing
  // ****************************************
  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef enum {ENG_IDLE, ENG_RUN} eac_eng_state_t;

  eac_eng_state_t state_q;
  logic [CW-1:0] cnt_q;
  eac_pkg::eac_mode_t op_q;
  logic rd_q;
  logic [8:0] addr_q;
  logic [7:0] data_q;
  logic fault_q;
  logic done_q;
  logic done_rd_q;
  logic hv_err_q;
  logic [7:0] rdata_q;
  logic [7:0] mem_q [eac_pkg::ARRAY_BYTES];
  logic [CW-1:0] last_c;
  logic finish;
  logic commit;
  logic fault_now;

  function automatic logic hits(input int unsigned idx,
                                input eac_pkg::eac_mode_t m,
                                input logic [8:0] a);
    logic [8:0] i9;
    i9 = 9'(idx);
    unique case (m)
      eac_pkg::MODE_BYTE: hits = (i9 == a);
      eac_pkg::MODE_RESERVED: hits = 1'b0;
      eac_pkg::MODE_ROW: hits = (i9[8:6] == a[8:6]);
      eac_pkg::MODE_BLOCK: hits = 1'b1;
    endcase
  endfunction

  // read is short, every program or fill takes the long count
  assign last_c = rd_q ? CW'(eac_pkg::READ_CYCLES - 1)
                       : CW'(PROG_CYCLES - 1);
  assign finish = (state_q == ENG_RUN) && (cnt_q == last_c);
  assign fault_now = fault_q | op_if.hv_fault;
  assign commit = finish && !rd_q && !fault_now;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ENG_IDLE;
    end else if (state_q == ENG_IDLE && op_if.start) begin
      state_q <= ENG_RUN;
    end else if (finish) begin
      state_q <= ENG_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (state_q == ENG_RUN) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      cnt_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= eac_pkg::MODE_BYTE;
      rd_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else if (state_q == ENG_IDLE && op_if.start) begin
      op_q <= op_if.op;
      rd_q <= op_if.rd;
      addr_q <= op_if.addr;
      data_q <= op_if.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else if (state_q == ENG_IDLE) begin
      fault_q <= 1'b0;
    end else if (op_if.hv_fault) begin
      fault_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      done_rd_q <= 1'b0;
      hv_err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= finish;
      done_rd_q <= finish && rd_q;
      hv_err_q <= finish && !rd_q && fault_now;
      if (finish && rd_q) begin
        rdata_q <= mem_q[addr_q];
      end
    end
  end

  // ****************************************
  // storage
  // ****************************************
  for (genvar g = 0; g < eac_pkg::ARRAY_BYTES; g++) begin : g_cell
    always_ff @(posedge clk) begin
      if (commit && hits(g, op_q, addr_q)) begin
        mem_q[g] <= data_q;
      end
    end
  end

  assign op_if.busy = (state_q == ENG_RUN);
  assign op_if.done = done_q;
  assign op_if.done_rd = done_rd_q;
  assign op_if.hv_err = hv_err_q;
  assign op_if.rdata = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  int len_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 0;
    end else if (state_q == ENG_RUN) begin
      len_q <= len_q + 1;
    end else begin
      len_q <= 0;
    end
  end

  property p_op_length;
    @(posedge clk) disable iff (!rst_n)
    done_q && !done_rd_q |-> $past(len_q) == PROG_CYCLES - 1;
  endproperty
  a_op_length: assert property (p_op_length)
    else $error("program cycle length wrong");

  property p_block_fill;
    @(posedge clk) disable iff (!rst_n)
    done_q && !hv_err_q && !rd_q && op_q == eac_pkg::MODE_BLOCK |->
      mem_q[0] == data_q && mem_q[eac_pkg::ARRAY_BYTES-1] == data_q;
  endproperty
  a_block_fill: assert property (p_block_fill)
    else $error("block fill did not reach array ends");

  property p_row_fill;
    @(posedge clk) disable iff (!rst_n)
    done_q && !hv_err_q && !rd_q && op_q == eac_pkg::MODE_ROW |->
      mem_q[{addr_q[8:6], 6'h3F}] == data_q &&
      mem_q[{addr_q[8:6], 6'h00}] == data_q;
  endproperty
  a_row_fill: assert property (p_row_fill)
    else $error("row fill did not cover row");

endmodule

// ---- sim/eac_ahb_host.sv ----
module eac_ahb_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // single word transfer, held until hready
  // ********
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = eac_pkg::SIZE_WORD;
    hwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
    // released data lines do not keep the last value
    hwdata <= ~hwdata;
  endtask
endmodule

// ---- sim/tb_data_eeprom_access_ctrl.sv ----
module tb_data_eeprom_access_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PC = 20;
  logic clk, rstn, hsel, hwrite, hv_fault, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] mem [512];
  logic [7:0] m_ctl, m_dat, m_low;
  logic m_arm, m_busy, m_en1, m_en0, m_hv, m_prog;
  int failures, num_checks, t0;
  int cyc = 0;

  eac_top #(.PROG_CYCLES(PC)) eac_top_inst (
    .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HV_FAULT(hv_fault), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .IRQ(irq));

  eac_ahb_host eac_ahb_host_inst (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ********
  // helpers and reference model
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] mval(input logic [31:0] a);
    case (a)
      32'h0000_0000: return m_ctl;
      32'h0000_0004: return m_dat;
      32'h0000_0008: return m_low;
      32'h0000_000C: return {m_en1, 7'h00};
      32'h0000_0010: return {m_en0, 7'h00};
      default: return 8'h00;
    endcase
  endfunction

  task do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    {m_ctl, m_dat, m_low} = 24'h00_0000;
    {m_arm, m_busy, m_en1, m_en0} = 4'h0;
  endtask

  task rd(input logic [31:0] a);
    logic [31:0] r;
    eac_ahb_host_inst.xfer(a, 1'b0, 32'h0000_0000, r);
    chk(r, {24'h00_0000, mval(a)});
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic [8:0] ea;
    eac_ahb_host_inst.xfer(a, 1'b1, {24'h00_0000, d}, r);
    ea = {m_ctl[0], d};
    case (a)
      32'h0000_0000: m_ctl = {m_ctl[7:6] & d[7:6], d[5:4], 3'h0, d[0]};
      32'h0000_0004: begin
        m_dat = d;
        if (m_ctl[5:4] == 2'h0) m_arm = 1'b1;
      end
      32'h0000_0008: begin
        m_low = d;
        if (!m_busy && m_ctl[5:4] != 2'h1) begin
          m_busy = 1'b1;
          m_prog = m_ctl[5:4] != 2'h0 || m_arm;
          m_hv = hv_fault & m_prog;
          t0 = cyc;
          if (!m_prog) m_dat = mem[ea];
          else if (!m_hv)
            for (int i = 0; i < 512; i++)
              if (m_ctl[5:4] == 2'h3 ||
                  (i[8:6] == ea[8:6] && (m_ctl[5] || i == ea)))
                mem[i] = m_dat;
          m_arm = 1'b0;
        end
      end
      32'h0000_000C: m_en1 = d[7];
      32'h0000_0010: m_en0 = d[7];
      default: ;
    endcase
  endtask

  task wait_done();
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0000_0000;
    while (r[7] !== 1'b1 && n < 100) begin
      eac_ahb_host_inst.xfer(32'h0000_0000, 1'b0, 32'h0000_0000, r);
      n++;
    end
    chk(r[7], 1'b1);
    chk(hresp, 1'b0);
    if (m_prog)
      chk($unsigned(cyc - t0 - PC) < 12, 1'b1);
    else chk(cyc - t0 < PC, 1'b1);
    m_busy = 1'b0;
    m_ctl[7] = 1'b1;
    m_ctl[6] = m_ctl[6] | m_hv;
    repeat (2) @(posedge clk);
    chk(irq, m_en1 & m_en0);
    rd(32'h0000_0000);
    rd(32'h0000_0004);
  endtask

  task readback(input logic [8:0] a);
    wr(32'h0000_0000, {7'h00, a[8]});
    wr(32'h0000_0008, a[7:0]);
    wait_done();
  endtask

  task finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    finish_test();
  end

  // ********
  // scenarios
  // ********
  initial begin
    rstn = 1'b0;
    hv_fault = 1'b0;
    seed = 32'h0001_7368;
    failures = 0;
    num_checks = 0;
    do_reset();
    for (int k = 0; k < 6; k++) rd(32'(k * 4));
    wr(32'h0000_0014, 8'(rnd()));
    rd(32'h0000_0014);
    wr(32'h0000_000C, 8'h80);
    wr(32'h0000_0000, 8'h01);
    wr(32'h0000_0010, 8'h00);
    wr(32'h0000_0004, 8'(rnd()));
    wr(32'h0000_0004, 8'(rnd()));
    wr(32'h0000_0008, 8'h12);
    wr(32'h0000_0008, 8'h34);
    wr(32'h0000_0010, 8'h80);
    wait_done();
    readback(9'h112);
    wr(32'h0000_0004, 8'(rnd()));
    do_reset();
    readback(9'h112);
    wr(32'h0000_0000, 8'h20);
    wr(32'h0000_0004, 8'(rnd()));
    wr(32'h0000_0008, 8'h47);
    wait_done();
    wr(32'h0000_0000, 8'h21);
    wr(32'h0000_0008, 8'h80);
    wait_done();
    readback(9'h040 | 9'(rnd() & 63));
    readback(9'h180 | 9'(rnd() & 63));
    readback(9'h112);
    for (int k = 0; k < 4; k++) begin
      wr(32'h0000_000C, {k[0], 7'h00});
      wr(32'h0000_0010, {k[1], 7'h00});
      repeat (2) @(posedge clk);
      chk(irq, k[0] & k[1]);
    end
    rd(32'h0000_0000);
    wr(32'h0000_0000, 8'h11);
    wr(32'h0000_0008, 8'h00);
    repeat (PC + 10) @(posedge clk);
    rd(32'h0000_0000);
    wr(32'h0000_0000, 8'h31);
    wr(32'h0000_0004, 8'(rnd()));
    wr(32'h0000_0008, 8'(rnd()));
    wait_done();
    for (int k = 0; k < 3; k++) readback(9'(rnd()));
    wr(32'h0000_0000, 8'h01);
    wr(32'h0000_0004, 8'(rnd()));
    hv_fault <= 1'b1;
    wr(32'h0000_0008, 8'h05);
    wait_done();
    hv_fault <= 1'b0;
    readback(9'h105);
    finish_test();
  end
endmodule
